// ### isolation_voting_logic.sv
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "iso_cfg.svh"
module isolation_voting_logic
  import iso_pkg::*;
#(
  parameter int N_VAR = `ISO_NUM_VAR
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [4*N_VAR-1:0] i_chan_trip,
  input wire plant_in_t i_plant,
  input wire open_sw_t i_open_sw,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output valve_t o_valve,
  output logic [3:0] o_mov_close,
  output logic o_probe_withdraw,
  output logic o_probe_valve_open
);

  localparam int PIN_W = 4 * N_VAR + $bits(plant_in_t) + $bits(open_sw_t);

  // At least two of the four bits set.
  function automatic logic vote2(input logic [3:0] v);
    logic [2:0] n;
    n = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    return n >= 3'd2;
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] pin_q;
  logic [4*N_VAR-1:0] chan_s;
  plant_in_t plant_s;
  open_sw_t sw_s;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      pin_q <= '0;
    end else begin
      meta_q <= {i_chan_trip, i_plant, i_open_sw};
      pin_q <= meta_q;
    end
  end

  assign {chan_s, plant_s, sw_s} = pin_q;

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic ctrl_reset_q;
  logic [3:0] ctrl_man_q;
  logic [3:0] trip_q;
  logic [3:0] vote_div;
  logic [3:0] bypass_q;
  logic [3:0] mov_q;
  probe_state_t probe_q;
  logic wb_req;
  logic wb_wr;

  assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;
  assign wb_wr = wb_req && i_wb_we && (i_wb_adr == `ISO_ADR_CTRL) && i_wb_sel[0];

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // The reset request bit self-clears so one write gives one reset attempt.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reset_q <= 1'b0;
      ctrl_man_q <= `ISO_CTRL_RST_VAL;
    end else begin
      ctrl_reset_q <= wb_wr && i_wb_dat[`ISO_CTRL_RESET_BIT];
      if (wb_wr) begin
        ctrl_man_q <= i_wb_dat[`ISO_CTRL_MAN_LSB +: 4];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdat_q <= '0;
    end else if (wb_req && !i_wb_we) begin
      case (i_wb_adr)
        `ISO_ADR_CTRL: rdat_q <= 32'({ctrl_man_q, 4'h0});
        `ISO_ADR_STATUS: rdat_q <= 32'({2'(probe_q), mov_q, bypass_q, vote_div, trip_q});
        `ISO_ADR_CHAN: rdat_q <= 32'(chan_s);
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // --------------------------------------------------------------------------
  // Divisional bypass interlock
  // --------------------------------------------------------------------------
  // Simultaneous key requests are all refused; an operator turning two keys
  // at once gets no bypass rather than an arbitrary one.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bypass_q <= `ISO_BYP_RST_VAL;
    end else if (bypass_q != 4'h0) begin
      if ((bypass_q & plant_s.bypass_key) == 4'h0) begin
        bypass_q <= 4'h0;
      end
    end else if ($onehot(plant_s.bypass_key)) begin
      bypass_q <= plant_s.bypass_key;
    end
  end

  // --------------------------------------------------------------------------
  // Channel voting
  // --------------------------------------------------------------------------
  logic [N_VAR-1:0] var_bypass;
  logic [N_VAR-1:0] var_vote;

  always_comb begin
    var_bypass = '0;
    var_bypass[`ISO_VAR_TURB_PRESS] = !plant_s.mode_run;
    var_bypass[`ISO_VAR_COND_VAC] = plant_s.dome_press_low || plant_s.stop_valve_lt90 ||
      plant_s.startup_vac_bypass;
  end

  // A bypassed channel reads as untripped, which turns two of four into two
  // of three on the remaining channels.
  genvar gv;
  generate
    for (gv = 0; gv < N_VAR; gv++) begin : g_var
      assign var_vote[gv] = !var_bypass[gv] && vote2(chan_s[4*gv +: 4] & ~bypass_q);
    end
  endgenerate

  // Each variable's channels are shared by all four voters, so the voters
  // agree; each still feeds only its own division's latch.
  genvar gd;
  generate
    for (gd = 0; gd < 4; gd++) begin : g_div
      assign vote_div[gd] = |var_vote;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Divisional trip latches
  // --------------------------------------------------------------------------
  logic [3:0] div_trip;
  logic reset_req;

  assign div_trip = vote_div | plant_s.manual_iso | ctrl_man_q;
  assign reset_req = plant_s.logic_reset || ctrl_reset_q;

  // A present initiating signal always sets, so it wins over a reset.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trip_q <= `ISO_TRIP_RST_VAL;
    end else if (reset_req) begin
      trip_q <= div_trip;
    end else begin
      trip_q <= trip_q | div_trip;
    end
  end

  // --------------------------------------------------------------------------
  // Valve drives
  // --------------------------------------------------------------------------
  valve_t valve_d;
  valve_t valve_q;
  logic any2;

  assign any2 = vote2(trip_q);

  always_comb begin
    valve_d.main_steam_isolation_valve_sol_a = !any2;
    valve_d.main_steam_isolation_valve_sol_b = !any2;
    valve_d.drain_outboard = sw_s.drain_outboard && !(trip_q[0] || trip_q[3]);
    valve_d.drain_inboard = sw_s.drain_inboard && !(trip_q[1] || trip_q[2]);
    valve_d.heat_loop_inboard = sw_s.heat_loop_inboard & ~trip_q[2:0];
    valve_d.heat_loop_outboard = sw_s.heat_loop_outboard & ~{trip_q[0], trip_q[2], trip_q[1]};
    valve_d.core_cool_inboard = sw_s.core_cool_inboard && !trip_q[0];
    valve_d.core_cool_outboard = sw_s.core_cool_outboard && !trip_q[1];
  end

  // Reset value zero means every valve is commanded closed from power-up.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valve_q <= '0;
    end else begin
      valve_q <= valve_d;
    end
  end

  assign o_valve = valve_q;

  // --------------------------------------------------------------------------
  // Motor-operated valve seal-in
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mov_q <= 4'h0;
    end else begin
      mov_q <= (mov_q | trip_q) & ~plant_s.mov_closed;
    end
  end

  assign o_mov_close = mov_q;

  // --------------------------------------------------------------------------
  // Traversing probe isolation sequence
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      probe_q <= PROBE_CLOSE;
    end else begin
      case (probe_q)
        PROBE_IDLE: begin
          if (plant_s.probe_trigger) begin
            probe_q <= PROBE_WITHDRAW;
          end
        end
        PROBE_WITHDRAW: begin
          if (plant_s.probe_withdrawn) begin
            probe_q <= PROBE_CLOSE;
          end
        end
        PROBE_CLOSE: begin
          if (reset_req && !plant_s.probe_trigger) begin
            probe_q <= PROBE_IDLE;
          end
        end
        default: probe_q <= PROBE_CLOSE;
      endcase
    end
  end

  // Outside reset, the ball and purge valves stay open through the withdrawal and close only
  // once the probe is clear, so a closing valve never meets the cable; reset closes them at once.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_probe_withdraw <= 1'b1;
      o_probe_valve_open <= 1'b0;
    end else begin
      o_probe_withdraw <= (probe_q != PROBE_IDLE);
      o_probe_valve_open <= (probe_q != PROBE_CLOSE);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_wb_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  a_wb_ack_once: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    s_wb_req |=> s_ack_pulse)
    else $error("Bus ack not a single cycle after request");

  a_trip_sets_latch: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (div_trip != 4'h0) |=> ((trip_q & $past(div_trip)) == $past(div_trip)))
    else $error("Division trip did not latch");

  a_latch_holds: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((~trip_q & $past(trip_q)) != 4'h0) |->
    ($past(reset_req) && ((~trip_q & $past(trip_q) & $past(div_trip)) == 4'h0)))
    else $error("Trip latch cleared without a valid reset");

  a_main_steam_isolation_valve_two_div: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    vote2(trip_q) |=> (!o_valve.main_steam_isolation_valve_sol_a && !o_valve.main_steam_isolation_valve_sol_b))
    else $error("Steam valve solenoids energised with two divisions tripped");

  a_drain_outboard: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (trip_q[0] || trip_q[3]) |=> !o_valve.drain_outboard)
    else $error("Outboard drain open while division one or four tripped");

  a_heat_loop_map: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    trip_q[0] |=> (!o_valve.heat_loop_inboard[0] && !o_valve.heat_loop_outboard[2] &&
    !o_valve.core_cool_inboard))
    else $error("Division one trip left a mapped valve open");

  a_bypass_single: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $onehot0(bypass_q))
    else $error("More than one divisional bypass in effect");

  a_bypass_kept: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((bypass_q != 4'h0) && ((bypass_q & plant_s.bypass_key) != 4'h0)) |=> $stable(bypass_q))
    else $error("Active bypass changed while its key held");

  sequence s_probe_withdraw;
    probe_q == PROBE_WITHDRAW;
  endsequence

  a_probe_order: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (probe_q == PROBE_IDLE) ##1 (probe_q != PROBE_IDLE) |-> s_probe_withdraw)
    else $error("Probe valves closed before withdrawal");

  a_seal_in: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (o_mov_close[0] && !plant_s.mov_closed[0]) |=> o_mov_close[0])
    else $error("Motor valve command dropped before full travel");

  a_drain_inboard: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (trip_q[1] || trip_q[2]) |=> !o_valve.drain_inboard)
    else $error("Inboard drain open while division two or three tripped");

  a_div_two_map: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    trip_q[1] |=> (!o_valve.heat_loop_inboard[1] && !o_valve.heat_loop_outboard[0] &&
    !o_valve.core_cool_outboard))
    else $error("Division two trip left a mapped valve open");

  a_div_three_map: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    trip_q[2] |=> (!o_valve.heat_loop_inboard[2] && !o_valve.heat_loop_outboard[1]))
    else $error("Division three trip left a mapped valve open");

  a_main_steam_isolation_valve_one_div: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !vote2(trip_q) |=> (o_valve.main_steam_isolation_valve_sol_a && o_valve.main_steam_isolation_valve_sol_b))
    else $error("Steam valve solenoids dropped with fewer than two divisions tripped");

  a_probe_clear: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $fell(o_probe_valve_open) |-> $past(o_probe_withdraw))
    else $error("Probe valves closed before withdrawal was commanded");

  a_bypass_refused: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((bypass_q == 4'h0) && !$onehot(plant_s.bypass_key)) |=> (bypass_q == 4'h0))
    else $error("Bypass granted for paired or absent keys");

  a_manual_div: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    plant_s.manual_iso[3] |=> trip_q[3])
    else $error("Manual pushbutton did not trip its division");

endmodule

// ### iso_cfg.svh
`ifndef ISO_CFG_SVH
`define ISO_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define ISO_ADR_CTRL 8'h00
`define ISO_ADR_STATUS 8'h04
`define ISO_ADR_CHAN 8'h08

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define ISO_CTRL_RESET_BIT 0
`define ISO_CTRL_MAN_LSB 4
`define ISO_CTRL_RST_VAL 4'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define ISO_STAT_TRIP_LSB 0
`define ISO_STAT_VOTE_LSB 4
`define ISO_STAT_BYP_LSB 8
`define ISO_STAT_MOV_LSB 12
`define ISO_STAT_PROBE_LSB 16

// ----------------------------------------------------------------------------
// Monitored variable indices and reset values
// ----------------------------------------------------------------------------
`define ISO_NUM_VAR 7
`define ISO_VAR_COND_VAC 5
`define ISO_VAR_TURB_PRESS 6
`define ISO_TRIP_RST_VAL 4'hf
`define ISO_BYP_RST_VAL 4'h0

`endif

// ### iso_pkg.sv
package iso_pkg;

  // Isolation outputs: high keeps the valve open (energised), low isolates.
  typedef struct packed {
    logic main_steam_isolation_valve_sol_a;
    logic main_steam_isolation_valve_sol_b;
    logic drain_outboard;
    logic drain_inboard;
    logic [2:0] heat_loop_inboard;
    logic [2:0] heat_loop_outboard;
    logic core_cool_inboard;
    logic core_cool_outboard;
  } valve_t;

  // Individual manual switch positions, high requests open.
  typedef struct packed {
    logic drain_outboard;
    logic drain_inboard;
    logic [2:0] heat_loop_inboard;
    logic [2:0] heat_loop_outboard;
    logic core_cool_inboard;
    logic core_cool_outboard;
  } open_sw_t;

  // Operator and plant permissive pins.
  typedef struct packed {
    logic [3:0] bypass_key;
    logic [3:0] manual_iso;
    logic logic_reset;
    logic startup_vac_bypass;
    logic mode_run;
    logic dome_press_low;
    logic stop_valve_lt90;
    logic probe_trigger;
    logic probe_withdrawn;
    logic [3:0] mov_closed;
  } plant_in_t;

  typedef enum logic [1:0] {
    PROBE_IDLE = 2'b00,
    PROBE_WITHDRAW = 2'b01,
    PROBE_CLOSE = 2'b10
  } probe_state_t;

endpackage

// ### iso_far_side.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Valve motors and probe drive
// ----------------------------------------------------------------------------
module iso_far_side
  import iso_pkg::*;
#(
  parameter int TRAVEL = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [3:0] i_mov_close,
  input wire logic i_probe_withdraw,
  input wire valve_t i_valve,
  output logic [3:0] o_mov_closed,
  output logic o_probe_withdrawn
);
  int stroke_q [4];
  int probe_q;

  // A motor reports closed only after a full stroke, so a short command would leave the valve half way.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stroke_q <= '{default: 0};
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (i_mov_close[d] && stroke_q[d] < TRAVEL) begin
          stroke_q[d] <= stroke_q[d] + 1;
        end else if (!i_mov_close[d] && &i_valve.heat_loop_inboard) begin
          stroke_q[d] <= 0;
        end
      end
    end
  end

  // The probe needs its own full stroke back before it reports withdrawn.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      probe_q <= 0;
    end else if (!i_probe_withdraw) begin
      probe_q <= 0;
    end else if (probe_q < TRAVEL) begin
      probe_q <= probe_q + 1;
    end
  end

  always_comb begin
    for (int d = 0; d < 4; d++) begin
      o_mov_closed[d] = stroke_q[d] >= TRAVEL;
    end
  end
  assign o_probe_withdrawn = probe_q >= TRAVEL;
endmodule

// ### test_isolation_voting_logic.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Bench for the divisional isolation logic
// ----------------------------------------------------------------------------
module test_isolation_voting_logic
  import iso_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [27:0] chan = 28'h0;
  plant_in_t p = 19'h00100;
  plant_in_t pin;
  open_sw_t sw = 10'h3ff;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] sel = 4'hf, movc, mcl;
  logic ack, pwd, pvo, pwn;
  valve_t valve;
  int n_fail = 0, samples_checked = 0;

  always #20 clk = ~clk;
  always_comb begin
    pin = p;
    pin.mov_closed = mcl;
    pin.probe_withdrawn = pwn;
  end

  isolation_voting_logic uut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_chan_trip(chan), .i_plant(pin),
    .i_open_sw(sw), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_valve(valve), .o_mov_close(movc),
    .o_probe_withdraw(pwd), .o_probe_valve_open(pvo));
  iso_far_side far (.i_clk_sys(clk), .i_arst_n(rst_n), .i_mov_close(movc), .i_probe_withdraw(pwd),
    .i_valve(valve), .o_mov_closed(mcl), .o_probe_withdrawn(pwn));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 60) begin
      n_fail++;
      $display("FAIL %0t wait timed out", $time);
      end_sim;
    end
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do tick(n); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic lreset;
    @(posedge clk);
    p.logic_reset <= 1'b1;
    repeat (4) @(posedge clk);
    p.logic_reset <= 1'b0;
    settle;
  endtask

  // Expected outputs follow from the latched divisions and the switch positions.
  function automatic valve_t ev(input logic [3:0] t);
    valve_t v;
    v.main_steam_isolation_valve_sol_a = $countones(t) < 2;
    v.main_steam_isolation_valve_sol_b = v.main_steam_isolation_valve_sol_a;
    v.drain_outboard = sw.drain_outboard & ~(t[0] | t[3]);
    v.drain_inboard = sw.drain_inboard & ~(t[1] | t[2]);
    v.heat_loop_inboard = sw.heat_loop_inboard & ~t[2:0];
    v.heat_loop_outboard = sw.heat_loop_outboard & ~{t[0], t[2], t[1]};
    v.core_cool_inboard = sw.core_cool_inboard & ~t[0];
    v.core_cool_outboard = sw.core_cool_outboard & ~t[1];
    return v;
  endfunction

  task automatic cv(input logic [3:0] t);
    chk({20'h0, valve}, {20'h0, ev(t)}, "valve");
  endtask

  task automatic t_power;
    chk({20'h0, valve}, 32'h0, "valve in reset");
    chk({30'h0, pwd, pvo}, 32'h2, "probe in reset");
    rst_n <= 1'b1;
    settle;
    cv(4'hf);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
    lreset;
    cv(4'h0);
    chk({30'h0, pwd, pvo}, 32'h1, "probe idle");
  endtask

  task automatic t_vote;
    for (int v = 0; v < 5; v++) begin
      chan <= 28'h1 << (4 * v);
      settle;
      cv(4'h0);
      chan <= 28'h9 << (4 * v);
      settle;
      cv(4'hf);
      wb(1'b0, 8'h04, 32'h0);
      chk(rdat & 32'hff, 32'hff, "latches and votes");
      lreset;
      cv(4'hf);
      chan <= 28'h0;
      lreset;
      cv(4'h0);
    end
  endtask

  task automatic t_manual;
    for (int d = 0; d < 4; d++) begin
      p.manual_iso <= 4'h1 << d;
      settle;
      cv(4'h1 << d);
      p.manual_iso <= 4'h0;
      lreset;
      cv(4'h0);
    end
    wb(1'b1, 8'h00, 32'h30);
    settle;
    cv(4'h3);
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h30, "manual readback");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    settle;
    cv(4'h0);
  endtask

  task automatic t_bypass;
    p.bypass_key <= 4'h1;
    settle;
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat & 32'hf00, 32'h100, "bypass");
    chan <= 28'h3;
    settle;
    cv(4'h0);
    chan <= 28'h6;
    settle;
    cv(4'hf);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h6, "channel readback");
    chan <= 28'h0;
    lreset;
    p.bypass_key <= 4'h3;
    settle;
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat & 32'hf00, 32'h100, "second bypass");
    p.bypass_key <= 4'h0;
    settle;
    p.bypass_key <= 4'h6;
    settle;
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat & 32'hf00, 32'h0, "paired keys");
    p.bypass_key <= 4'h0;
    settle;
  endtask

  task automatic t_oper;
    p.mode_run <= 1'b0;
    chan <= 28'h3 << 24;
    settle;
    cv(4'h0);
    p.mode_run <= 1'b1;
    settle;
    cv(4'hf);
    chan <= 28'h0;
    lreset;
    for (int k = 0; k < 4; k++) begin
      {p.dome_press_low, p.stop_valve_lt90, p.startup_vac_bypass} <= (k == 3) ? 3'b000 : 3'b001 << k;
      chan <= 28'h3 << 20;
      settle;
      cv((k == 3) ? 4'hf : 4'h0);
      chan <= 28'h0;
      lreset;
    end
  endtask

  task automatic t_mov;
    int n;
    n = 0;
    while (movc !== 4'h0) tick(n);
    chan <= 28'h3;
    n = 0;
    while (movc !== 4'hf) tick(n);
    chan <= 28'h0;
    lreset;
    cv(4'h0);
    chk({28'h0, movc}, 32'hf, "seal-in");
    n = 0;
    while (movc !== 4'h0) tick(n);
    chk({28'h0, mcl}, 32'hf, "full travel");
  endtask

  task automatic t_probe;
    int n;
    p.probe_trigger <= 1'b1;
    n = 0;
    while (pwd !== 1'b1) tick(n);
    chk({31'h0, pvo}, 32'h1, "valves before withdraw");
    n = 0;
    while (pvo !== 1'b0) tick(n);
    chk({31'h0, pwn}, 32'h1, "closed after withdraw");
    p.probe_trigger <= 1'b0;
    lreset;
    chk({30'h0, pwd, pvo}, 32'h1, "probe rearmed");
  endtask

  // A second reset in mid-run must bring back the tripped, isolating state.
  task automatic t_rst;
    rst_n <= 1'b0;
    @(posedge clk);
    chk({20'h0, valve}, 32'h0, "valve in second reset");
    chk({30'h0, pwd, pvo}, 32'h2, "probe in second reset");
    rst_n <= 1'b1;
    settle;
    cv(4'hf);
    sw <= 10'h2aa;
    lreset;
    cv(4'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t run timed out", $time);
    end_sim;
  end

  initial begin
    repeat (4) @(posedge clk);
    t_power;
    t_vote;
    t_manual;
    t_bypass;
    t_oper;
    t_mov;
    t_probe;
    t_rst;
    end_sim;
  end
endmodule
